//--- src/main_channel_priority_arbiter.v
// main channel priority arbiter with apb status and control registers
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "arb_defs.vh"

module main_channel_priority_arbiter (
	input wire pclk,
	input wire presetn,
	input wire [31:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [3:0] selector_subchannel_data_req,
	input wire multiplex_subchannel_req,
	input wire [3:0] selector_subchannel_sec_req,
	input wire main_channel_req,
	input wire cpu_req,
	input wire busy_release,
	output reg [10:0] response,
	output reg response_delayed,
	output reg channel_busy,
	output reg priority_check,
	output reg control_reset,
	output reg irq
);

	// ****************************************
	// helpers
	// ****************************************
	function [10:0] highest;
		input [10:0] v;
		integer i;
		begin
			highest = 11'h000;
			for (i = `N_REQ - 1; i >= 0; i = i - 1) begin
				if (v[i] && highest == 11'h000) begin
					highest = 11'h001 << i;
				end
			end
		end
	endfunction

	function [4:0] cnt_next;
		input [4:0] c;
		begin
			cnt_next = (c != 5'h00) ? c - 5'h01 : 5'h00;
		end
	endfunction

	function reg_mapped;
		input [11:0] adr;
		begin
			reg_mapped = (adr == `REG_STATUS) || (adr == `REG_MASK) || (adr == `REG_STATE) ||
				(adr == `REG_CONTROL) || (adr == `REG_GRANT);
		end
	endfunction

	// ****************************************
	// request synchronisers
	// ****************************************
	// bit 10 highest: ssc data 1..4, msc, ssc secondary 1..4, main channel, cpu
	wire [10:0] req_pin;
	assign req_pin = {selector_subchannel_data_req, multiplex_subchannel_req,
		selector_subchannel_sec_req, main_channel_req, cpu_req};
	reg [11:0] s1_q, s2_q, s3_q, sf_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 12'h000;
			s2_q <= 12'h000;
			s3_q <= 12'h000;
			sf_q <= 12'h000;
		end else begin
			s1_q <= {busy_release, req_pin};
			s2_q <= s1_q;
			s3_q <= s2_q;
			sf_q <= (s2_q ~^ s3_q) & s2_q | ~(s2_q ~^ s3_q) & sf_q;
		end
	end
	wire [10:0] req_s = sf_q[10:0];
	wire release_s = sf_q[11];

	// ****************************************
	// pulse counters and latches
	// ****************************************
	reg [4:0] rr_q, sr_q, bz_q, sd_q, sp_q, dr_q;
	reg [10:0] req_latch_q;
	reg sample_latch_q, resp_check_q, check_q, sample_block_q;
	reg [31:0] status_q, mask_q, ctl_q;
	wire rr_on = rr_q != 5'h00;
	wire sr_on = sr_q != 5'h00;
	wire bz_on = bz_q != 5'h00;
	wire sp_on = sp_q != 5'h00;
	wire sampling = sample_latch_q && !sample_block_q && !sp_on && ctl_q[`CTL_SAMPLE_EN];
	wire common_req = req_latch_q != 11'h000;
	wire launch = common_req && !channel_busy && !rr_on && !sr_on && !resp_check_q;
	wire gate_on = sr_on && !rr_on;
	wire sample_fire = sd_q == 5'h01;
	wire busy_clear = channel_busy && release_s;
	wire chk_err = sample_fire && (!check_q || ((req_s & response) != 11'h000));

	wire apb_acc = psel && penable && !pready;
	wire apb_wr = psel && penable && pwrite && pready;
	wire apb_rd = apb_acc && !pwrite;
	wire [11:0] a = paddr[11:0];
	wire [2:0] ev = {common_req && channel_busy, launch, chk_err};

	// pulse lengths trimmed to the counter width
	wire [31:0] rr_len = `RST_RESP_CYC;
	wire [31:0] sr_len = `SET_RESP_CYC;
	wire [31:0] bz_len = `BUSY_CYC;
	wire [31:0] sd_len = `SAMPLE_DELAY_CYC;
	wire [31:0] sp_len = `SAMPLE_CYC;
	wire [31:0] dr_len = `DLY_RESP_CYC;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rr_q <= 5'h00;
			sr_q <= 5'h00;
			bz_q <= 5'h00;
			sd_q <= 5'h00;
			sp_q <= 5'h00;
			dr_q <= 5'h00;
			req_latch_q <= 11'h000;
			sample_latch_q <= 1'b1;
			sample_block_q <= 1'b0;
			resp_check_q <= 1'b0;
			check_q <= 1'b0;
			response <= 11'h000;
		end else begin
			// pulse counters count down every cycle
			rr_q <= cnt_next(rr_q);
			sr_q <= cnt_next(sr_q);
			bz_q <= cnt_next(bz_q);
			sd_q <= cnt_next(sd_q);
			sp_q <= cnt_next(sp_q);
			dr_q <= cnt_next(dr_q);
			if (sampling) begin
				req_latch_q <= req_latch_q | req_s;
			end
			if (launch) begin
				rr_q <= rr_len[4:0];
				sr_q <= sr_len[4:0];
				sample_latch_q <= 1'b0;
			end
			if (rr_on) begin
				response <= 11'h000;
				resp_check_q <= 1'b0;
				check_q <= 1'b0;
			end else if (gate_on && response == 11'h000) begin
				response <= highest(req_latch_q);
				req_latch_q <= req_latch_q & ~highest(req_latch_q);
				check_q <= (highest(req_latch_q) & req_s) != 11'h000;
			end
			if (sr_q == 5'h01) begin
				resp_check_q <= 1'b1;
				bz_q <= bz_len[4:0];
				sd_q <= sd_len[4:0];
			end
			if (sample_fire) begin
				sp_q <= sp_len[4:0];
				sample_latch_q <= 1'b1;
				sample_block_q <= !channel_busy;
			end
			if (channel_busy) begin
				sample_block_q <= 1'b0;
			end
			if (busy_clear) begin
				resp_check_q <= 1'b0;
			end
			if (bz_q == 5'h01) begin
				dr_q <= dr_len[4:0];
			end
		end
	end

	// busy latch: set the cycle after the busy count loads, released by the requester
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_busy <= 1'b0;
		end else if (busy_clear) begin
			channel_busy <= 1'b0;
		end else if (bz_q == bz_len[4:0]) begin
			channel_busy <= 1'b1;
		end
	end

	// delayed response pulse from busy timeout, lasting its own count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			response_delayed <= 1'b0;
		end else if (busy_clear) begin
			response_delayed <= 1'b0;
		end else if (bz_q == 5'h01) begin
			response_delayed <= 1'b1;
		end else if (dr_q == 5'h01) begin
			response_delayed <= 1'b0;
		end
	end

	// one-cycle check and control reset pulses
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priority_check <= 1'b0;
			control_reset <= 1'b0;
		end else begin
			priority_check <= chk_err;
			control_reset <= launch && (resp_check_q || check_q);
		end
	end

	// ****************************************
	// apb registers and interrupt
	// ****************************************
	// ready and error answer together, one cycle into the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_acc;
			pslverr <= apb_acc && !reg_mapped(a);
		end
	end

	// writes land on the edge that sees pready high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 32'h0000_0000;
			ctl_q <= `CTL_RESET_VALUE;
		end else begin
			if (apb_wr && a == `REG_MASK) begin
				mask_q <= pwdata & 32'h0000_0007;
			end
			if (apb_wr && a == `REG_CONTROL) begin
				ctl_q <= pwdata & 32'h0000_0001;
			end
		end
	end

	// sticky events, a new event wins over a clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= 32'h0000_0000;
		end else begin
			if (apb_wr && a == `REG_STATUS) begin
				status_q <= {29'h0, (status_q[2:0] & ~pwdata[2:0]) | ev};
			end else begin
				status_q <= {29'h0, status_q[2:0] | ev};
			end
		end
	end

	// read data stands by the edge where pready is high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_rd) begin
			case (a)
				`REG_STATUS: prdata <= status_q;
				`REG_MASK: prdata <= mask_q;
				`REG_STATE: prdata <= {26'h0, check_q, resp_check_q,
					sample_latch_q, channel_busy, response_delayed, common_req};
				`REG_CONTROL: prdata <= ctl_q;
				`REG_GRANT: prdata <= {10'h0, req_latch_q, response};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// level interrupt from unmasked sticky bits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (status_q[2:0] & mask_q[2:0]) != 3'h0;
		end
	end

endmodule

//--- src/arb_defs.vh
// constants of the main channel priority arbiter
`ifndef ARB_DEFS_VH
`define ARB_DEFS_VH
`define CLK_PERIOD_NS 25
`define N_REQ 11
`define RST_RESP_NS 50
`define RST_RESP_CYC ((`RST_RESP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SET_RESP_NS 100
`define SET_RESP_CYC ((`SET_RESP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_NS 200
`define BUSY_CYC ((`BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_DELAY_NS 400
`define SAMPLE_DELAY_CYC ((`SAMPLE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_NS 100
`define SAMPLE_CYC ((`SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_RESP_NS 100
`define DLY_RESP_CYC ((`DLY_RESP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CTRL_RST_CYC 1
`define REG_STATUS 12'h000
`define REG_MASK 12'h004
`define REG_STATE 12'h008
`define REG_CONTROL 12'h00c
`define REG_GRANT 12'h010
`define ST_CHECK 0
`define ST_GRANT 1
`define ST_PEND 2
`define CTL_SAMPLE_EN 0
`define CTL_RESET_VALUE 32'h0000_0001
`define CNT_W 5
`endif

//--- verification/arb_checker.sv
// arbiter port assertions
`timescale 1ns/1ps
module arb_checker (
	input wire pclk,
	input wire presetn,
	input wire [10:0] response,
	input wire response_delayed,
	input wire channel_busy,
	input wire priority_check,
	input wire control_reset
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
a_one_grant: assert property ($onehot0(response)) else $error("grant");
a_busy_hold: assert property (channel_busy && $past(channel_busy) |-> $stable(response))
	else $error("hold");
a_busy_soon: assert property ($rose(|response) |-> !channel_busy ##[1:12] channel_busy)
	else $error("busy");
a_delay_soon: assert property ($rose(channel_busy) |-> ##[1:16] response_delayed)
	else $error("delay");
a_delay_qual: assert property (response_delayed |-> channel_busy && |response)
	else $error("qual");
a_delay_end: assert property ($rose(response_delayed) |-> ##[1:8] !response_delayed)
	else $error("end");
a_check_pulse: assert property (priority_check |-> |response ##1 !priority_check)
	else $error("check");
a_ctrl_reset: assert property (control_reset |-> !channel_busy ##1 !control_reset)
	else $error("ctrl");
endmodule
bind main_channel_priority_arbiter arb_checker arb_checker_inst (.*);

//--- verification/requester_model.sv
// requester model
`timescale 1ns/1ps
module requester_model (
	input wire pclk,
	input wire presetn,
	input wire [10:0] raise,
	input wire stuck,
	input wire [10:0] response,
	input wire response_delayed,
	input wire channel_busy,
	output reg [10:0] req_q,
	output reg busy_release
);
reg seen_q;
always @(posedge pclk or negedge presetn)
	if (!presetn) {req_q, seen_q, busy_release} <= '0;
	else begin
		req_q <= (req_q | raise) & ~(stuck ? 11'h000 : response);
		seen_q <= response_delayed | (seen_q & channel_busy);
		busy_release <= seen_q & ~response_delayed & ~stuck & channel_busy;
	end
endmodule

//--- verification/test_main_channel_priority_arbiter.sv
// bench of the priority arbiter
`timescale 1ns/1ps
module test_main_channel_priority_arbiter;
logic pclk = 1'b0, presetn, psel, penable, pwrite, stuck, ia, err, pready, pslverr, irq;
logic multiplex_subchannel_req, main_channel_req, cpu_req, busy_release, response_delayed;
logic channel_busy, priority_check, control_reset;
logic [31:0] paddr, pwdata, prdata, rd;
logic [10:0] raise, response, req_q;
logic [3:0] pstrb, selector_subchannel_data_req, selector_subchannel_sec_req;
int n_errors = 0, comparisons = 0, n_ctrl = 0, n_pchk = 0;
always @(posedge pclk) begin
	if (control_reset === 1'b1) n_ctrl++;
	if (priority_check === 1'b1) n_pchk++;
end
assign {selector_subchannel_data_req, multiplex_subchannel_req, selector_subchannel_sec_req,
	main_channel_req, cpu_req} = req_q;
main_channel_priority_arbiter main_channel_priority_arbiter_inst (.*);
requester_model requester_model_inst (.*);
task chk(input string s, input logic [31:0] seen, exp);
	comparisons++;
	if (seen !== exp) begin
		n_errors++;
		$display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
	end
endtask
task give_verdict;
	$display("%0d errors %0d checks", n_errors, comparisons);
	if (n_errors == 0 && comparisons > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask
task apb(input logic w, input logic [31:0] a, d);
	@(posedge pclk);
	{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
	@(posedge pclk);
	penable <= 1'b1;
	do @(posedge pclk); while (pready !== 1'b1);
	{err, rd} = {pslverr, prdata};
	{psel, penable} <= 2'b00;
	repeat (2) @(negedge pclk);
endtask
initial forever #12.5 pclk = ~pclk;
initial begin
	repeat (5000) @(posedge pclk);
	n_errors++;
	give_verdict;
end
task t_prio;
	@(posedge pclk) raise <= 11'h7ff;
	@(posedge pclk) raise <= 11'h000;
	for (int i = 10; i >= 0; i--) begin
		do @(negedge pclk); while (response_delayed !== 1'b1);
		chk("grant", response, 32'h1 << i);
		do @(negedge pclk); while (channel_busy !== 1'b0);
	end
	chk("ctrl resets", n_ctrl, 32'd10);
	chk("no check", n_pchk, 32'd0);
endtask
task t_gate;
	apb(1'b0, 32'h020, 32'h0);
	chk("unmapped", {rd[30:0], err}, 32'h1);
	apb(1'b0, 32'h00c, 32'h0);
	chk("control reset value", rd, 32'h1);
	apb(1'b1, 32'h00c, 32'h0);
	@(posedge pclk);
	{stuck, raise} <= {1'b1, 11'h002};
	@(posedge pclk) raise <= 11'h000;
	repeat (40) @(negedge pclk);
	chk("gated", channel_busy, 32'h0);
	apb(1'b1, 32'h00c, 32'h1);
	do @(negedge pclk); while (priority_check !== 1'b1);
	chk("held", response, 32'h2);
	@(posedge pclk) stuck <= 1'b0;
	do @(negedge pclk); while (channel_busy !== 1'b0);
	repeat (60) @(negedge pclk);
	apb(1'b1, 32'h004, 32'h0);
	ia = irq;
	apb(1'b1, 32'h004, 32'h7);
	chk("irq mask", ia ^ irq, 32'h1);
	apb(1'b1, 32'h000, 32'h7);
	chk("irq clear", irq, 32'h0);
endtask
initial begin
	{presetn, psel, penable, pwrite, paddr, pwdata, pstrb, raise, stuck} = '0;
	repeat (12) @(posedge pclk);
	presetn <= 1'b1;
	t_prio;
	t_gate;
	give_verdict;
end
endmodule
